/* File: design/ee2w_pkg.sv */
package ee2w_pkg;
	// core clock and the self-timed program cycle
	localparam int CLK_HZ = 100_000_000;
	localparam int WRITE_CYCLE_TIME_MS = 5;
	localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_MS * (CLK_HZ / 1000);

	// storage organisation
	localparam int PAGE_COUNT = 256;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_W = $clog2(PAGE_COUNT);
	localparam int OFFSET_W = $clog2(PAGE_BYTES);
	localparam int WORD_ADDR_W = PAGE_W + OFFSET_W;

	// address byte layout
	localparam int DEV_TYPE_MSB = 7;
	localparam int DEV_TYPE_LSB = 4;
	localparam int STRAP_MSB = 3;
	localparam int STRAP_LSB = 1;
	localparam int RW_BIT = 0;
	// first word-address byte carries the top word-address bits here
	localparam int WADDR_HI_MSB = 4;
	localparam int WADDR_HI_W = WADDR_HI_MSB + 1;

	// device type code: value is arbitrary
	localparam logic [3:0] DEV_TYPE_CODE = 4'h6;

	// bit slots of one byte on the wire
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_CLOCK = 4'h9;

	typedef struct packed {
		logic [PAGE_W-1:0] page;
		logic [OFFSET_W-1:0] offset;
	} ee2w_waddr_t;

	typedef struct packed {
		logic sclRise;
		logic sclFall;
		logic start;
		logic stop;
		logic sda;
	} ee2w_evt_t;
endpackage

/* File: design/ee2w_line_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module ee2w_line_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclPin,
	input wire logic sdaPin,
	input wire logic [2:0] strapPins,
	output ee2w_pkg::ee2w_evt_t evt,
	output logic [2:0] strapLevel
);
	logic [1:0] scl1_q;
	logic [1:0] sda1_q;
	logic [2:0] strap1_q;
	logic [1:0] scl2_q;
	logic [1:0] sda2_q;

	// idle bus is high on both lines
	always_ff @(posedge clk) begin
		if (rst) begin
			scl1_q <= 2'h3;
			sda1_q <= 2'h3;
			scl2_q <= 2'h3;
			sda2_q <= 2'h3;
		end else begin
			scl1_q <= {scl1_q[0], sclPin};
			sda1_q <= {sda1_q[0], sdaPin};
			scl2_q <= {scl2_q[0], scl1_q[1]};
			sda2_q <= {sda2_q[0], sda1_q[1]};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			strap1_q <= 3'h0;
			strapLevel <= 3'h0;
		end else begin
			strap1_q <= strapPins;
			strapLevel <= strap1_q;
		end
	end

	// scl2_q[0] is the current level, scl2_q[1] the one before
	always_comb begin
		evt.sclRise = scl2_q[0] & ~scl2_q[1];
		evt.sclFall = ~scl2_q[0] & scl2_q[1];
		evt.start = &scl2_q & sda2_q[1] & ~sda2_q[0];
		evt.stop = &scl2_q & ~sda2_q[1] & sda2_q[0];
		evt.sda = sda2_q[0];
	end
endmodule
`default_nettype wire

/* File: design/ee2w_write_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module ee2w_write_timer #(
	parameter int CYCLES = ee2w_pkg::WRITE_CYCLE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic launch,
	output logic busy,
	output logic done
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (launch && cnt_q == '0) begin
			cnt_q <= CW'(CYCLES);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign busy = cnt_q != '0;
	assign done = cnt_q == CW'(1);

	chk_timer_load: assert property (@(posedge clk) disable iff (rst)
		launch && !busy |=> cnt_q == CW'(CYCLES))
		else $error("program timer did not load its full count");
endmodule
`default_nettype wire

/* File: design/ee2w_client.sv */
`timescale 1ns/10ps
`default_nettype none
module ee2w_client #(
	parameter int WRITE_CYCLES = ee2w_pkg::WRITE_CYCLE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclPin,
	input wire logic sdaPin,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic clientStrapBit0,
	input wire logic clientStrapBit1,
	input wire logic clientStrapBit2,
	input wire logic [7:0] readData,
	output ee2w_pkg::ee2w_waddr_t memAddr,
	output logic [7:0] memData,
	output logic memWrite,
	output logic standby,
	output logic writeBusy
);
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_DEVADDR,
		ST_WADDR_HI,
		ST_WADDR_LO,
		ST_DATA,
		ST_DATA_DONE,
		ST_READ,
		ST_IGNORE
	} ee2w_state_t;

	ee2w_pkg::ee2w_evt_t evt;
	logic [2:0] strapLevel;
	ee2w_state_t state_q;
	logic [3:0] bitCnt_q;
	logic [7:0] shift_q;
	logic [7:0] txShift_q;
	logic txDrive_q;
	logic ackDrive_q;
	logic hostAck_q;
	logic [ee2w_pkg::WADDR_HI_W-1:0] addrHi_q;
	ee2w_pkg::ee2w_waddr_t addr_q;
	logic [7:0] data_q;
	logic memWrite_q;
	logic timerDone;
	logic ackSlot;
	logic ninthFall;
	logic ackWanted;
	logic loadTx;
	logic launch;
	logic active;

	function automatic logic devMatch(input logic [7:0] b, input logic [2:0] straps);
		devMatch = b[ee2w_pkg::DEV_TYPE_MSB:ee2w_pkg::DEV_TYPE_LSB] == ee2w_pkg::DEV_TYPE_CODE
			&& b[ee2w_pkg::STRAP_MSB:ee2w_pkg::STRAP_LSB] == straps;
	endfunction

	// whole 13-bit counter wraps, crossing page boundaries
	function automatic ee2w_pkg::ee2w_waddr_t nextAddr(input ee2w_pkg::ee2w_waddr_t a);
		nextAddr = ee2w_pkg::ee2w_waddr_t'(a + 1'b1);
	endfunction

	ee2w_line_sync u_sync (
		.clk(clk),
		.rst(rst),
		.sclPin(sclPin),
		.sdaPin(sdaPin),
		.strapPins({clientStrapBit2, clientStrapBit1, clientStrapBit0}),
		.evt(evt),
		.strapLevel(strapLevel)
	);

	ee2w_write_timer #(
		.CYCLES(WRITE_CYCLES)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.launch(launch),
		.busy(writeBusy),
		.done(timerDone)
	);

	assign ackSlot = evt.sclFall && bitCnt_q == ee2w_pkg::BITS_PER_BYTE;
	assign ninthFall = evt.sclFall && bitCnt_q == ee2w_pkg::ACK_CLOCK;
	assign active = state_q != ST_STANDBY && state_q != ST_IGNORE;
	assign launch = evt.stop && state_q == ST_DATA_DONE && !writeBusy;
	assign loadTx = (state_q == ST_DEVADDR && shift_q[ee2w_pkg::RW_BIT] && ackDrive_q)
		|| (state_q == ST_READ && hostAck_q);

	// extra data bytes past the first are refused: only byte write is kept
	always_comb begin
		case (state_q)
			ST_DEVADDR: ackWanted = devMatch(shift_q, strapLevel);
			ST_WADDR_HI: ackWanted = 1'b1;
			ST_WADDR_LO: ackWanted = 1'b1;
			ST_DATA: ackWanted = 1'b1;
			default: ackWanted = 1'b0;
		endcase
	end

	// open drain: only ever pulls low
	assign sdaOut = 1'b0;
	assign sdaOe = ackDrive_q | txDrive_q;
	assign standby = state_q == ST_STANDBY && !writeBusy;
	assign memAddr = addr_q;
	assign memData = data_q;
	assign memWrite = memWrite_q;

	// bit counter and receive shifter
	always_ff @(posedge clk) begin
		if (rst) begin
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			hostAck_q <= 1'b0;
		end else if (writeBusy || evt.start || evt.stop) begin
			bitCnt_q <= 4'h0;
		end else if (ackSlot && state_q == ST_DEVADDR && !ackWanted) begin
			// refused byte: no ninth fall will clear it, so park the counter now
			bitCnt_q <= 4'h0;
		end else if (evt.sclRise && active) begin
			if (bitCnt_q < ee2w_pkg::BITS_PER_BYTE) begin
				shift_q <= {shift_q[6:0], evt.sda};
			end else begin
				hostAck_q <= !evt.sda;
			end
			bitCnt_q <= bitCnt_q + 1'b1;
		end else if (ninthFall) begin
			bitCnt_q <= 4'h0;
		end
	end

	// protocol state
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_STANDBY;
		end else if (writeBusy) begin
			state_q <= ST_STANDBY;
		end else if (evt.start) begin
			state_q <= ST_DEVADDR;
		end else if (evt.stop) begin
			state_q <= ST_STANDBY;
		end else if (ackSlot && state_q == ST_DEVADDR && !ackWanted) begin
			state_q <= ST_IGNORE;
		end else if (ninthFall) begin
			case (state_q)
				ST_DEVADDR: begin
					if (shift_q[ee2w_pkg::RW_BIT]) begin
						state_q <= ST_READ;
					end else begin
						state_q <= ST_WADDR_HI;
					end
				end
				ST_WADDR_HI: state_q <= ST_WADDR_LO;
				ST_WADDR_LO: state_q <= ST_DATA;
				ST_DATA: state_q <= ST_DATA_DONE;
				ST_READ: state_q <= hostAck_q ? ST_READ : ST_IGNORE;
				default: state_q <= state_q;
			endcase
		end
	end

	// acknowledge driver: set at the fall ending bit eight, cleared at the end of the ninth
	always_ff @(posedge clk) begin
		if (rst || writeBusy || evt.start || evt.stop) begin
			ackDrive_q <= 1'b0;
		end else if (ackSlot) begin
			ackDrive_q <= ackWanted;
		end else if (ninthFall) begin
			ackDrive_q <= 1'b0;
		end
	end

	// transmit driver for read data, next bit put out on each fall except the one ending bit eight, which releases the line
	always_ff @(posedge clk) begin
		if (rst || writeBusy || evt.start || evt.stop) begin
			txDrive_q <= 1'b0;
			txShift_q <= 8'h00;
		end else if (ninthFall) begin
			txDrive_q <= loadTx && !readData[7];
			txShift_q <= {readData[6:0], 1'b0};
		end else if (ackSlot) begin
			txDrive_q <= 1'b0;
		end else if (evt.sclFall && state_q == ST_READ && bitCnt_q != 4'h0) begin
			txDrive_q <= !txShift_q[7];
			txShift_q <= {txShift_q[6:0], 1'b0};
		end
	end

	// word address, data byte and current address counter
	always_ff @(posedge clk) begin
		if (rst) begin
			addrHi_q <= '0;
			addr_q <= '0;
			data_q <= 8'h00;
		end else if (timerDone) begin
			addr_q <= nextAddr(addr_q);
		end else if (ackSlot && state_q == ST_WADDR_HI) begin
			addrHi_q <= shift_q[ee2w_pkg::WADDR_HI_MSB:0];
		end else if (ackSlot && state_q == ST_WADDR_LO) begin
			addr_q <= ee2w_pkg::ee2w_waddr_t'({addrHi_q, shift_q});
		end else if (ackSlot && state_q == ST_DATA) begin
			data_q <= shift_q;
		end else if (evt.sclRise && state_q == ST_READ && bitCnt_q == ee2w_pkg::BITS_PER_BYTE) begin
			addr_q <= nextAddr(addr_q);
		end
	end

	// one-cycle program request to the storage array
	always_ff @(posedge clk) begin
		if (rst) begin
			memWrite_q <= 1'b0;
		end else begin
			memWrite_q <= launch;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_ackSlot;
		evt.sclFall && bitCnt_q == 4'h8;
	endsequence

	sequence s_ninthFall;
		evt.sclFall && bitCnt_q == 4'h9;
	endsequence

	sequence s_hostNack;
		state_q == ST_READ && evt.sclFall && bitCnt_q == 4'h9 && !hostAck_q;
	endsequence

	chk_start_leaves_standby: assert property (
		evt.start && !writeBusy |=> state_q == ST_DEVADDR && bitCnt_q == 4'h0 && !standby)
		else $error("start did not open an address byte");

	chk_stop_to_standby: assert property (
		evt.stop && !writeBusy && state_q != ST_DATA_DONE |=> standby && !sdaOe)
		else $error("stop did not return to standby");

	chk_sda_moves_scl_low: assert property (
		$changed(sdaOe) |-> $past(evt.sclFall || evt.start || evt.stop || writeBusy))
		else $error("data line drive changed outside an scl fall");

	chk_ack_whole_ninth: assert property (
		ackDrive_q && !(evt.sclFall && bitCnt_q == 4'h9) && !evt.start && !evt.stop && !writeBusy |=> ackDrive_q)
		else $error("acknowledge dropped inside the ninth clock");

	chk_ack_release: assert property (
		s_ninthFall |=> !ackDrive_q)
		else $error("acknowledge not released after the ninth clock");

	chk_nack_release: assert property (
		s_hostNack |=> !sdaOe && state_q == ST_IGNORE)
		else $error("data line still driven after host nack");

	chk_ignore_released: assert property (
		state_q == ST_IGNORE |-> !sdaOe && bitCnt_q == 4'h0)
		else $error("device active after refused address");

	chk_mismatch_nack: assert property (
		s_ackSlot and (state_q == ST_DEVADDR && !devMatch(shift_q, strapLevel)) |=> !ackDrive_q && state_q == ST_IGNORE)
		else $error("mismatching address byte was acknowledged");

	chk_busy_silent: assert property (
		writeBusy |-> !sdaOe && state_q == ST_STANDBY && !standby)
		else $error("device answered during the program cycle");

	chk_write_launch: assert property (
		evt.stop && state_q == ST_DATA_DONE && !writeBusy |=> memWrite && writeBusy ##1 !memWrite)
		else $error("stop after data byte did not start programming");

	chk_waddr_load: assert property (
		s_ackSlot and (state_q == ST_WADDR_LO && !evt.start && !evt.stop && !writeBusy)
		|=> memAddr == ee2w_pkg::ee2w_waddr_t'({$past(addrHi_q), $past(shift_q)}))
		else $error("word address not assembled from both bytes");

	chk_tx_msb_first: assert property (
		state_q == ST_READ && evt.sclFall && bitCnt_q > 4'h0 && bitCnt_q < 4'h8 && !evt.start && !evt.stop
		|=> txDrive_q == !$past(txShift_q[7]))
		else $error("read data not shifted out msb first");
endmodule
`default_nettype wire

/* File: verif/ee2w_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ee2w_host_model (
	output logic scl,
	output logic sdaLow,
	input wire logic sda
);
	localparam realtime Q = 31.25;
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	// opens every command but the one after recover, also serves as repeated start
	task automatic startCond();
		sdaLow = 1'b0;
		#Q scl = 1'b1;
		#Q sdaLow = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic stopCond();
		sdaLow = 1'b1;
		#Q scl = 1'b1;
		#Q sdaLow = 1'b0;
		#Q;
		#Q;
	endtask
	// data moves only a quarter period after the fall
	task automatic bitCyc(input logic drive, output logic seen);
		sdaLow = drive;
		#Q scl = 1'b1;
		#Q seen = sda;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic writeByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitCyc(~b[i], s);
		end
		bitCyc(1'b0, s);
		ack = ~s;
	endtask
	task automatic readByte(input logic hostAck, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitCyc(1'b0, b[i]);
		end
		bitCyc(hostAck, s);
	endtask
	// clock until the line is free, then start while scl is high
	task automatic recover(output int n);
		n = 0;
		sdaLow = 1'b0;
		do begin
			n++;
			#Q scl = 1'b1;
			#Q;
			if (sda !== 1'b1) begin
				#Q scl = 1'b0;
				#Q;
			end
		end while (sda !== 1'b1 && n < 9);
		#Q sdaLow = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask
endmodule
`default_nettype wire

/* File: verif/i2c_eeprom_client_protocol_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module i2c_eeprom_client_protocol_tb_top;
	localparam int WCYC = 200;
	localparam logic [2:0] STRAP = 3'h5;
	localparam logic [7:0] DEVW = {ee2w_pkg::DEV_TYPE_CODE, STRAP, 1'b0};
	localparam logic [7:0] DEVR = {ee2w_pkg::DEV_TYPE_CODE, STRAP, 1'b1};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] straps = STRAP;
	logic hostLow, scl, sdaOut, sdaOe, memWrite, standby, writeBusy, a;
	logic [7:0] mem [0:8191];
	logic [7:0] memData, readData, wrData, rd;
	logic [12:0] wrAddr;
	ee2w_pkg::ee2w_waddr_t memAddr;
	int num_errors = 0;
	int compares = 0;
	int writes = 0;
	wire sdaLine;
	// pull-up wire-AND of both parties
	assign sdaLine = ~(hostLow | (sdaOe & ~sdaOut));
	assign readData = mem[memAddr];
	always #5 clk = ~clk;
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = i[7:0];
		end
	end
	always @(posedge clk) begin
		if (memWrite) begin
			writes <= writes + 1;
			wrAddr <= memAddr;
			wrData <= memData;
			mem[memAddr] <= memData;
		end
	end
	ee2w_client #(.WRITE_CYCLES(WCYC)) uut (.clk(clk), .rst(rst), .sclPin(scl), .sdaPin(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .clientStrapBit0(straps[0]), .clientStrapBit1(straps[1]),
		.clientStrapBit2(straps[2]), .readData(readData), .memAddr(memAddr), .memData(memData),
		.memWrite(memWrite), .standby(standby), .writeBusy(writeBusy));
	ee2w_host_model host (.scl(scl), .sdaLow(hostLow), .sda(sdaLine));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic setAddr(input logic [12:0] ad);
		host.startCond();
		chk("standby after start", 16'h0, 16'(standby));
		host.writeByte(DEVW, a);
		chk("address ack", 16'h1, 16'(a));
		host.writeByte({3'h7, ad[12:8]}, a);
		chk("word hi ack", 16'h1, 16'(a));
		host.writeByte(ad[7:0], a);
		chk("word lo ack", 16'h1, 16'(a));
	endtask
	task automatic testReset();
		chk("reset standby", 16'h1, 16'(standby));
		chk("reset drive", 16'h0, 16'({sdaOe, writeBusy, memWrite, sdaOut}));
		chk("reset addr", 16'h0, 16'(memAddr));
		chk("reset data", 16'h0, 16'(memData));
	endtask
	task automatic testMismatch();
		for (int k = 0; k < 4; k++) begin
			host.startCond();
			host.writeByte(DEVW ^ (8'h02 << k), a);
			chk("foreign address nack", 16'h0, 16'(a));
			host.writeByte(8'h00, a);
			chk("ignored after nack", 16'h0, 16'(a));
			host.stopCond();
		end
	endtask
	task automatic testWrite(input logic [12:0] ad, input logic [7:0] d);
		int w0;
		w0 = writes;
		setAddr(ad);
		host.writeByte(d, a);
		chk("data ack", 16'h1, 16'(a));
		// only byte write is kept: a second data byte goes unanswered
		host.writeByte(~d, a);
		chk("extra byte nack", 16'h0, 16'(a));
		host.stopCond();
		for (int i = 0; i < 20 && writes == w0; i++) @(posedge clk);
		@(negedge clk);
		chk("program count", 16'(w0 + 1), 16'(writes));
		chk("program addr", 16'(ad), 16'(wrAddr));
		chk("program data", 16'(d), 16'(wrData));
		chk("busy", 16'h1, 16'(writeBusy));
		host.startCond();
		host.writeByte(DEVW, a);
		chk("ack while busy", 16'h0, 16'(a));
		host.stopCond();
		for (int i = 0; i < WCYC && writeBusy; i++) @(posedge clk);
		@(negedge clk);
		chk("standby after program", 16'h1, 16'(standby));
		chk("address after program", 16'({ad + 13'h1}), 16'(memAddr));
	endtask
	// read across the top of the array into location zero
	task automatic testRead(input logic [7:0] d);
		setAddr(13'h1fff);
		host.startCond();
		host.writeByte(DEVR, a);
		chk("read address ack", 16'h1, 16'(a));
		host.readByte(1'b1, rd);
		chk("read byte 0", 16'(d), 16'(rd));
		host.readByte(1'b0, rd);
		chk("read wrap byte", 16'h0, 16'(rd));
		repeat (6) @(posedge clk);
		chk("release after nack", 16'h0, 16'(sdaOe));
		host.stopCond();
		repeat (6) @(posedge clk);
		chk("standby after stop", 16'h1, 16'(standby));
	endtask
	// abandon a read while the device holds the line low
	task automatic testRecover();
		int n;
		int w0;
		w0 = writes;
		setAddr(13'h0100);
		host.startCond();
		host.writeByte(DEVR, a);
		host.recover(n);
		chk("dummy clocks", 16'h9, 16'(n));
		host.writeByte(DEVW, a);
		chk("ack after recovery", 16'h1, 16'(a));
		host.stopCond();
		repeat (6) @(posedge clk);
		chk("no program", 16'(w0), 16'(writes));
		chk("standby", 16'h1, 16'(standby));
	endtask
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		repeat (4) @(negedge clk);
		testReset();
		testMismatch();
		testWrite(13'h1fff, 8'ha6);
		testRead(8'ha6);
		testRecover();
		test_done();
	end
	initial begin
		#500000;
		num_errors++;
		test_done();
	end
endmodule
`default_nettype wire
